/* shared/bzr_defines.svh */
`ifndef BZR_DEFINES_SVH
`define BZR_DEFINES_SVH

// reset values of the configuration fields
`define BZR_FMSTR_RST     2'h0
`define BZR_RATE_RST      1'h0
`define BZR_LPF_RST       2'h1
`define BZR_MOD_RST       4'h8
`define BZR_MAG_RST       3'h0

// low-pass codes
`define BZR_LPF_BYPASS    2'h0
`define BZR_LPF_DEFAULT   2'h1
`define BZR_LPF_MID       2'h2
`define BZR_LPF_HIGH      2'h3

// magnitude codes
`define BZR_MAG_OFF       3'h0
`define BZR_MAG_8UA       3'h1
`define BZR_MAG_16UA      3'h2
`define BZR_MAG_32UA      3'h3
`define BZR_MAG_64UA      3'h5
`define BZR_MAG_96UA      3'h7

// modulation codes
`define BZR_MOD_128K      4'h0
`define BZR_MOD_80K       4'h1
`define BZR_MOD_40K       4'h2
`define BZR_MOD_18K       4'h3
`define BZR_MOD_DIV4      4'h4
`define BZR_MOD_DIV8      4'h5
`define BZR_MOD_DIV16     4'h6
`define BZR_MOD_DIV32     4'h7
`define BZR_MOD_DIV64     4'h8
`define BZR_MOD_DIV128    4'h9

// master clock rates in Hz
`define BZR_FMSTR0_HZ     16'h8000
`define BZR_FMSTR12_HZ    16'h7D00
`define BZR_FMSTR3_HZ     16'h7CE0

// sample rates in hundredths of sps
`define BZR_RATE0_FAST    13'h1900
`define BZR_RATE0_SLOW    13'h0C80
`define BZR_RATE1_FAST    13'h186A
`define BZR_RATE1_SLOW    13'h0C35
`define BZR_RATE2_FAST    13'h1388
`define BZR_RATE2_SLOW    13'h09C4
`define BZR_RATE3_FAST    13'h1383
`define BZR_RATE3_SLOW    13'h0A26

// low-pass cutoffs in mHz
`define BZR_CUT0_LOW      15'h1000
`define BZR_CUT0_MID      15'h2000
`define BZR_CUT0_HIGH     15'h4000
`define BZR_CUT12_LOW     15'h0FA0
`define BZR_CUT12_MID     15'h1F40
`define BZR_CUT12_HIGH    15'h3E80
`define BZR_CUT3_LOW      15'h0F9C
`define BZR_CUT3_MID      15'h1F38
`define BZR_CUT3_HIGH     15'h3E70

// modulation frequencies in Hz
`define BZR_F0_128K       18'h20000
`define BZR_F12_128K      18'h1F400
`define BZR_F3_128K       18'h1F380
`define BZR_FA_80K        18'h14000
`define BZR_FB_80K        18'h13880
`define BZR_FA_40K        18'h0A000
`define BZR_FB_40K        18'h09C40
`define BZR_FA_18K        18'h0471C
`define BZR_FB_18K        18'h04574
`define BZR_F0_512        18'h00200
`define BZR_FX_500        18'h001F4
`define BZR_F0_256        18'h00100
`define BZR_FX_250        18'h000FA
`define BZR_F0_128        18'h00080
`define BZR_FX_125        18'h0007D

// core clock timing
`define BZR_CLK_PERIOD_NS 5
`define BZR_CLK_HZ        (1000000000 / `BZR_CLK_PERIOD_NS)

`endif

/* shared/bzr_pkg.sv */
`default_nettype none

package bzr_pkg;

  typedef enum logic [1:0] {
    BZR_FM_32768,
    BZR_FM_32000A,
    BZR_FM_32000B,
    BZR_FM_31968
  } bzr_fmstr_t;

  typedef struct packed {
    bzr_fmstr_t  masterClockSelect;
    logic        rateSlow;
    logic [1:0]  lowpassCutoffSelect;
    logic [3:0]  modulationFreqSelect;
    logic [2:0]  driveCurrentMagnitude;
  } bzr_cfg_t;

  typedef struct packed {
    logic [1:0]  lowpassEffective;
    logic [14:0] cutoffMhz;
    logic [12:0] rateCsps;
    logic [17:0] modFreqHz;
  } bzr_res_t;

endpackage : bzr_pkg

`default_nettype wire

/* design/bzr_drive_gen.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bzr_defines.svh"

module bzr_drive_gen (
  input  wire logic        core_clk,    // core clock
  input  wire logic        srst,        // sync reset, high
  input  wire logic        enable,      // generator running
  input  wire logic [17:0] modFreqHz,   // wanted output frequency
  output var  logic        drivePos,    // positive phase
  output var  logic        driveNeg     // negative phase
);
  import bzr_pkg::*;

  localparam logic [27:0] CLK_HZ = 28'(`BZR_CLK_HZ);

  logic [27:0] acc_r;
  logic [27:0] acc_nxt;
  logic        pos_r;
  logic        pos_nxt;
  logic        neg_r;
  logic        neg_nxt;
  logic [28:0] sum;

  // two half periods per cycle, so step by twice the frequency
  always_comb begin
    sum     = {1'b0, acc_r} + {10'h000, modFreqHz, 1'b0};
    acc_nxt = acc_r;
    pos_nxt = pos_r;
    if (!enable) begin
      acc_nxt = 28'h0000000;
      pos_nxt = 1'b0;
    end else if (sum >= {1'b0, CLK_HZ}) begin
      acc_nxt = 28'(sum - {1'b0, CLK_HZ});
      pos_nxt = !pos_r;
    end else begin
      acc_nxt = sum[27:0];
    end
    // registered so the negative phase leaves the block straight from a flop
    neg_nxt = enable & !pos_nxt;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      acc_r <= 28'h0000000;
      pos_r <= 1'b0;
      neg_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      pos_r <= pos_nxt;
      neg_r <= neg_nxt;
    end
  end

  assign drivePos = pos_r;
  assign driveNeg = neg_r;

endmodule : bzr_drive_gen

`default_nettype wire

/* design/bzr_setting_resolver.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bzr_defines.svh"

module bzr_setting_resolver (
  input  wire logic              core_clk,       // 200 MHz clock
  input  wire logic              srst,           // sync reset, high
  input  wire logic              cfgWrEn,        // write strobe, one cycle
  input  wire bzr_pkg::bzr_cfg_t cfgWrData,      // settings written
  input  wire logic              illegalClr,     // clears illegal flag
  output var  bzr_pkg::bzr_cfg_t cfgStored,      // settings as stored
  output var  bzr_pkg::bzr_res_t resolved,       // derived settings
  output var  logic              illegalSetting, // sticky illegal flag
  output var  logic              driveOutPos,    // positive drive
  output var  logic              driveOutPosOeN, // low while driving
  output var  logic              driveOutNeg,    // negative drive
  output var  logic              driveOutNegOeN  // low while driving
);
  import bzr_pkg::*;

  // effective low-pass code: 16 Hz only at the fast rates
  function automatic logic [1:0] eff_lpf(input bzr_cfg_t c);
    if (c.rateSlow && c.lowpassCutoffSelect == `BZR_LPF_HIGH)
      return `BZR_LPF_DEFAULT;
    return c.lowpassCutoffSelect;
  endfunction : eff_lpf

  function automatic logic [14:0] cutoff_of(input bzr_fmstr_t fm, input logic [1:0] lpf);
    logic [14:0] low;
    logic [14:0] mid;
    logic [14:0] high;
    unique case (fm)
      BZR_FM_32768: begin
        low  = `BZR_CUT0_LOW;
        mid  = `BZR_CUT0_MID;
        high = `BZR_CUT0_HIGH;
      end
      BZR_FM_32000A, BZR_FM_32000B: begin
        low  = `BZR_CUT12_LOW;
        mid  = `BZR_CUT12_MID;
        high = `BZR_CUT12_HIGH;
      end
      BZR_FM_31968: begin
        low  = `BZR_CUT3_LOW;
        mid  = `BZR_CUT3_MID;
        high = `BZR_CUT3_HIGH;
      end
    endcase
    unique case (lpf)
      `BZR_LPF_BYPASS:  return 15'h0000;
      `BZR_LPF_DEFAULT: return low;
      `BZR_LPF_MID:     return mid;
      `BZR_LPF_HIGH:    return high;
    endcase
  endfunction : cutoff_of

  function automatic logic [12:0] rate_of(input bzr_fmstr_t fm, input logic slow);
    unique case (fm)
      BZR_FM_32768:  return slow ? `BZR_RATE0_SLOW : `BZR_RATE0_FAST;
      BZR_FM_32000A: return slow ? `BZR_RATE1_SLOW : `BZR_RATE1_FAST;
      BZR_FM_32000B: return slow ? `BZR_RATE2_SLOW : `BZR_RATE2_FAST;
      BZR_FM_31968:  return slow ? `BZR_RATE3_SLOW : `BZR_RATE3_FAST;
    endcase
  endfunction : rate_of

  function automatic logic [17:0] mod_of(input bzr_fmstr_t fm, input logic [3:0] code);
    logic        grpA;
    logic        fm0;
    logic [15:0] fmHz;
    // the 80K, 40K and 18K codes pair 00 with 11, unlike the divided ones
    grpA = (fm == BZR_FM_32768) || (fm == BZR_FM_31968);
    fm0  = (fm == BZR_FM_32768);
    fmHz = fm0 ? `BZR_FMSTR0_HZ : ((fm == BZR_FM_31968) ? `BZR_FMSTR3_HZ : `BZR_FMSTR12_HZ);
    unique case (code)
      `BZR_MOD_128K: begin
        if (fm0)
          return `BZR_F0_128K;
        return (fm == BZR_FM_31968) ? `BZR_F3_128K : `BZR_F12_128K;
      end
      `BZR_MOD_80K:  return grpA ? `BZR_FA_80K : `BZR_FB_80K;
      `BZR_MOD_40K:  return grpA ? `BZR_FA_40K : `BZR_FB_40K;
      `BZR_MOD_18K:  return grpA ? `BZR_FA_18K : `BZR_FB_18K;
      `BZR_MOD_DIV4, `BZR_MOD_DIV8, `BZR_MOD_DIV16, `BZR_MOD_DIV32:
        return {2'h0, fmHz >> (code - 4'h2)};
      `BZR_MOD_DIV64:  return fm0 ? `BZR_F0_512 : `BZR_FX_500;
      `BZR_MOD_DIV128: return fm0 ? `BZR_F0_256 : `BZR_FX_250;
      default:         return fm0 ? `BZR_F0_128 : `BZR_FX_125;
    endcase
  endfunction : mod_of

  // largest magnitude code the modulation code permits
  function automatic logic [2:0] mag_limit(input logic [3:0] code);
    unique case (code)
      `BZR_MOD_128K, `BZR_MOD_18K: return `BZR_MAG_96UA;
      `BZR_MOD_80K, `BZR_MOD_40K:  return `BZR_MAG_96UA;
      `BZR_MOD_DIV4:               return `BZR_MAG_96UA - 3'h1;
      `BZR_MOD_DIV8:               return `BZR_MAG_32UA;
      `BZR_MOD_DIV16:              return `BZR_MAG_16UA;
      default:                     return `BZR_MAG_8UA;
    endcase
  endfunction : mag_limit

  bzr_cfg_t    cfg_r;
  bzr_cfg_t    cfg_nxt;
  bzr_res_t    res_r;
  bzr_res_t    res_nxt;
  logic        ill_r;
  logic        ill_nxt;
  logic        oeN_r;
  logic        oeN_nxt;
  logic        wrIllegal;
  logic        genPos;
  logic        genNeg;

  // settings store; an illegal magnitude leaves the old one in place
  always_comb begin
    wrIllegal = cfgWrEn && (cfgWrData.driveCurrentMagnitude >
                            mag_limit(cfgWrData.modulationFreqSelect));
    cfg_nxt = cfg_r;
    if (cfgWrEn) begin
      cfg_nxt = cfgWrData;
      if (wrIllegal)
        cfg_nxt.driveCurrentMagnitude = cfg_r.driveCurrentMagnitude;
    end
    // a new illegal write wins over a clear in the same cycle
    ill_nxt = wrIllegal ? 1'b1 : (illegalClr ? 1'b0 : ill_r);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_r <= '{masterClockSelect:     bzr_fmstr_t'(`BZR_FMSTR_RST),
                 rateSlow:              `BZR_RATE_RST,
                 lowpassCutoffSelect:   `BZR_LPF_RST,
                 modulationFreqSelect:  `BZR_MOD_RST,
                 driveCurrentMagnitude: `BZR_MAG_RST};
      ill_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      ill_r <= ill_nxt;
    end
  end

  // derived view lags the store by one cycle
  always_comb begin
    res_nxt.lowpassEffective = eff_lpf(cfg_r);
    res_nxt.cutoffMhz        = cutoff_of(cfg_r.masterClockSelect, eff_lpf(cfg_r));
    res_nxt.rateCsps         = rate_of(cfg_r.masterClockSelect, cfg_r.rateSlow);
    res_nxt.modFreqHz        = mod_of(cfg_r.masterClockSelect, cfg_r.modulationFreqSelect);
    oeN_nxt = (cfg_r.driveCurrentMagnitude == `BZR_MAG_OFF);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      res_r <= '0;
      oeN_r <= 1'b1;
    end else begin
      res_r <= res_nxt;
      oeN_r <= oeN_nxt;
    end
  end

  bzr_drive_gen u_gen (
    .core_clk  (core_clk),
    .srst      (srst),
    .enable    (!oeN_r),
    .modFreqHz (res_r.modFreqHz),
    .drivePos  (genPos),
    .driveNeg  (genNeg)
  );

  assign cfgStored      = cfg_r;
  assign resolved       = res_r;
  assign illegalSetting = ill_r;
  assign driveOutPos    = genPos;
  assign driveOutNeg    = genNeg;
  assign driveOutPosOeN = oeN_r;
  assign driveOutNegOeN = oeN_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  chk_fast_cutoff16: assert property (
    cfg_r.masterClockSelect == BZR_FM_32768 && !cfg_r.rateSlow &&
    cfg_r.lowpassCutoffSelect == `BZR_LPF_HIGH |=> res_r.cutoffMhz == 15'h4000)
    else $error("fast rate cutoff 16.384 Hz missing");
  chk_slow_remap: assert property (
    cfg_r.masterClockSelect == BZR_FM_32768 && cfg_r.rateSlow &&
    cfg_r.lowpassCutoffSelect == `BZR_LPF_HIGH
    |=> res_r.cutoffMhz == 15'h1000 && res_r.lowpassEffective == 2'h1)
    else $error("slow rate code 11 not remapped");
  chk_default_subst: assert property (
    cfg_r.rateSlow && cfg_r.lowpassCutoffSelect == `BZR_LPF_HIGH
    |=> res_r.lowpassEffective == `BZR_LPF_DEFAULT)
    else $error("unsupported lowpass not substituted");
  chk_rate_fm01: assert property (
    cfg_r.masterClockSelect == BZR_FM_32000A && !cfg_r.rateSlow |=> res_r.rateCsps == 13'h186A)
    else $error("62.5 sps rate wrong");
  chk_mid_fm10: assert property (
    cfg_r.masterClockSelect == BZR_FM_32000B && cfg_r.lowpassCutoffSelect == `BZR_LPF_MID
    |=> res_r.cutoffMhz == 15'h1F40)
    else $error("8.0 Hz cutoff wrong");
  chk_high_fm11: assert property (
    cfg_r.masterClockSelect == BZR_FM_31968 && !cfg_r.rateSlow &&
    cfg_r.lowpassCutoffSelect == `BZR_LPF_HIGH |=> res_r.cutoffMhz == 15'h3E70)
    else $error("15.984 Hz cutoff wrong");
  chk_mod_top: assert property (
    cfg_r.modulationFreqSelect == 4'h0 && cfg_r.masterClockSelect == BZR_FM_31968
    |=> res_r.modFreqHz == 18'h1F380)
    else $error("127872 Hz modulation wrong");
  chk_mod_80k: assert property (
    cfg_r.modulationFreqSelect == 4'h1 && cfg_r.masterClockSelect == BZR_FM_31968
    |=> res_r.modFreqHz == 18'h14000)
    else $error("81920 Hz modulation wrong");
  chk_mod_div32: assert property (
    cfg_r.modulationFreqSelect == 4'h7 && cfg_r.masterClockSelect == BZR_FM_31968
    |=> res_r.modFreqHz == 18'h003E7)
    else $error("999 Hz modulation wrong");
  chk_mod_lowest: assert property (
    cfg_r.modulationFreqSelect[3] && |cfg_r.modulationFreqSelect[2:1] &&
    cfg_r.masterClockSelect == BZR_FM_32768 |=> res_r.modFreqHz == 18'h00080)
    else $error("128 Hz modulation wrong");
  chk_lpf_stored: assert property (
    cfgWrEn |=> cfg_r.lowpassCutoffSelect == $past(cfgWrData.lowpassCutoffSelect))
    else $error("written lowpass code not stored");
  chk_off_float: assert property (
    cfg_r.driveCurrentMagnitude == 3'h0 |=> driveOutPosOeN && driveOutNegOeN)
    else $error("drive not floating with magnitude off");
  chk_merged_allow: assert property (
    cfgWrEn && cfgWrData.modulationFreqSelect == 4'h3 && !illegalClr
    |=> cfg_r.driveCurrentMagnitude == $past(cfgWrData.driveCurrentMagnitude))
    else $error("merged code refused a magnitude");
  chk_illegal_keep: assert property (
    cfgWrEn && cfgWrData.modulationFreqSelect == 4'h6 && cfgWrData.driveCurrentMagnitude == 3'h3
    |=> illegalSetting && $stable(cfg_r.driveCurrentMagnitude)
        ##1 (illegalSetting || $past(illegalClr)))
    else $error("illegal pair not flagged or magnitude changed");

  chk_mod_40k: assert property (
    cfg_r.modulationFreqSelect == 4'h2 && cfg_r.masterClockSelect == BZR_FM_32000B
    |=> res_r.modFreqHz == 18'h09C40)
    else $error("40000 Hz modulation wrong");
  chk_mod_18k: assert property (
    cfg_r.modulationFreqSelect == 4'h3 && cfg_r.masterClockSelect == BZR_FM_31968
    |=> res_r.modFreqHz == 18'h0471C)
    else $error("18204 Hz modulation wrong");
  chk_mod_div64: assert property (
    cfg_r.modulationFreqSelect == 4'h8 && cfg_r.masterClockSelect == BZR_FM_31968
    |=> res_r.modFreqHz == 18'h001F4)
    else $error("500 Hz modulation wrong");
  chk_bypass_zero: assert property (
    cfg_r.lowpassCutoffSelect == 2'h0 |=> res_r.cutoffMhz == 15'h0000 && res_r.lowpassEffective == 2'h0)
    else $error("lowpass bypass not kept");
  chk_rate_slow11: assert property (
    cfg_r.masterClockSelect == BZR_FM_31968 && cfg_r.rateSlow |=> res_r.rateCsps == 13'h0A26)
    else $error("25.98 sps rate wrong");
  chk_allow_high: assert property (
    cfgWrEn && (cfgWrData.modulationFreqSelect == 4'h1 || cfgWrData.modulationFreqSelect == 4'h2)
    |=> cfg_r.driveCurrentMagnitude == $past(cfgWrData.driveCurrentMagnitude))
    else $error("high frequency refused a magnitude");
  chk_refuse_96: assert property (
    cfgWrEn && cfgWrData.modulationFreqSelect == 4'h4 && cfgWrData.driveCurrentMagnitude == 3'h7
    |=> illegalSetting)
    else $error("largest magnitude at code 0100 not flagged");
  chk_refuse_div8: assert property (
    cfgWrEn && cfgWrData.modulationFreqSelect == 4'h5 && cfgWrData.driveCurrentMagnitude > 3'h3
    |=> illegalSetting)
    else $error("magnitude above 32 uA at code 0101 not flagged");
  chk_refuse_low: assert property (
    cfgWrEn && cfgWrData.modulationFreqSelect >= 4'h7 && cfgWrData.driveCurrentMagnitude > 3'h1
    |=> illegalSetting && $stable(cfg_r.driveCurrentMagnitude))
    else $error("magnitude above 8 uA at low frequency accepted");
  chk_clear_flag: assert property (
    illegalClr && !cfgWrEn |=> !illegalSetting)
    else $error("illegal flag not cleared");
  chk_drive_opposite: assert property (
    driveOutPos |-> !driveOutNeg)
    else $error("drive phases overlap");
  chk_off_quiet: assert property (
    driveOutPosOeN |=> !driveOutPos && !driveOutNeg)
    else $error("drive toggling while floating");

  cov_remap: cover property (cfg_r.rateSlow && cfg_r.lowpassCutoffSelect == 2'h3);
  cov_illegal: cover property (cfgWrEn && wrIllegal);
  cov_drive_toggle: cover property (!oeN_r && $changed(genPos));
  cov_set_and_clear: cover property (wrIllegal && illegalClr);
  cov_slow_fm11: cover property (cfg_r.masterClockSelect == BZR_FM_31968 && cfg_r.rateSlow);

endmodule : bzr_setting_resolver

`default_nettype wire

/* testbench/bzr_testbench.sv */
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import bzr_pkg::*;

  typedef struct packed {
    bzr_cfg_t cfg;
    logic     ill;
  } bzr_note_a_t;

  typedef struct packed {
    bzr_res_t res;
    logic     oeN;
  } bzr_note_b_t;

  logic        core_clk;
  logic        srst;
  logic        cfgWrEn;
  bzr_cfg_t    cfgWrData;
  logic        illegalClr;
  bzr_cfg_t    cfgStored;
  bzr_res_t    resolved;
  logic        illegalSetting;
  logic        driveOutPos;
  logic        driveOutPosOeN;
  logic        driveOutNeg;
  logic        driveOutNegOeN;
  logic        enD1 = 1'b0;
  logic        enD2 = 1'b0;
  bzr_cfg_t    expCfg;
  logic        expIll;
  logic [31:0] rng;
  bzr_cfg_t    d;
  bzr_note_a_t na;
  bzr_note_b_t nb;
  int          toggles;
  int          badCnt;
  logic        prevPos;
  int          n_errors;
  int          n_checks;
  bzr_note_a_t noteA[$];
  bzr_note_b_t noteB[$];

  bzr_setting_resolver dut_u (
    .core_clk       (core_clk),
    .srst           (srst),
    .cfgWrEn        (cfgWrEn),
    .cfgWrData      (cfgWrData),
    .illegalClr     (illegalClr),
    .cfgStored      (cfgStored),
    .resolved       (resolved),
    .illegalSetting (illegalSetting),
    .driveOutPos    (driveOutPos),
    .driveOutPosOeN (driveOutPosOeN),
    .driveOutNeg    (driveOutNeg),
    .driveOutNegOeN (driveOutNegOeN)
  );

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xorshift

  // highest magnitude code the host may pair with each modulation code
  function automatic logic [2:0] mag_limit(input logic [3:0] m);
    case (m)
      4'h0, 4'h1, 4'h2, 4'h3: return 3'h7;
      4'h4:    return 3'h6;
      4'h5:    return 3'h3;
      4'h6:    return 3'h2;
      default: return 3'h1;
    endcase
  endfunction : mag_limit

  function automatic bzr_res_t res_exp(input bzr_cfg_t c);
    bzr_res_t    r;
    logic [17:0] fm;
    logic [17:0] base;
    logic [14:0] low;
    logic [3:0]  m;
    logic        alt;
    m = c.modulationFreqSelect;
    alt = (c.masterClockSelect == BZR_FM_32000A) || (c.masterClockSelect == BZR_FM_32000B);
    case (c.masterClockSelect)
      BZR_FM_32768:  {fm, low, r.rateCsps} = {18'h08000, 15'h1000, c.rateSlow ? 13'h0C80 : 13'h1900};
      BZR_FM_32000A: {fm, low, r.rateCsps} = {18'h07D00, 15'h0FA0, c.rateSlow ? 13'h0C35 : 13'h186A};
      BZR_FM_32000B: {fm, low, r.rateCsps} = {18'h07D00, 15'h0FA0, c.rateSlow ? 13'h09C4 : 13'h1388};
      default:       {fm, low, r.rateCsps} = {18'h07CE0, 15'h0F9C, c.rateSlow ? 13'h0A26 : 13'h1383};
    endcase
    r.lowpassEffective = (c.rateSlow && c.lowpassCutoffSelect == 2'h3) ? 2'h1 : c.lowpassCutoffSelect;
    // cutoffs double per code step, so one base value per master clock suffices
    r.cutoffMhz = (r.lowpassEffective == 2'h0) ? 15'h0000 : low << (r.lowpassEffective - 2'h1);
    base = (c.masterClockSelect == BZR_FM_32768) ? 18'h00200 : 18'h001F4;
    case (m)
      4'h0:    r.modFreqHz = fm << 2;
      4'h1:    r.modFreqHz = alt ? 18'h13880 : 18'h14000;
      4'h2:    r.modFreqHz = alt ? 18'h09C40 : 18'h0A000;
      4'h3:    r.modFreqHz = alt ? 18'h04574 : 18'h0471C;
      4'h4, 4'h5, 4'h6, 4'h7: r.modFreqHz = fm >> (m - 4'h2);
      default: r.modFreqHz = base >> ((m >= 4'hA) ? 4'h2 : m - 4'h8);
    endcase
    return r;
  endfunction : res_exp

  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic stop_test;
    if (n_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  // one cycle of stimulus; the model is updated in the same call so notes stay in write order
  task automatic step(input logic en, input bzr_cfg_t dat, input logic clr);
    logic     bad;
    bzr_cfg_t c;
    @(posedge core_clk);
    #1;
    cfgWrEn = en;
    cfgWrData = dat;
    illegalClr = clr;
    bad = en && (dat.driveCurrentMagnitude > mag_limit(dat.modulationFreqSelect));
    if (en) begin
      c = dat;
      if (bad) c.driveCurrentMagnitude = expCfg.driveCurrentMagnitude;
      expCfg = c;
    end
    // a flagged write wins over a clear in the same cycle
    if (bad) expIll = 1'b1;
    else if (clr) expIll = 1'b0;
    if (en) begin
      noteA.push_back('{expCfg, expIll});
      noteB.push_back('{res_exp(expCfg), expCfg.driveCurrentMagnitude == 3'h0});
    end
  endtask : step

  always @(posedge core_clk) begin
    enD1 <= cfgWrEn & ~srst;
    enD2 <= enD1;
  end

  always @(negedge core_clk) begin
    if (enD1) begin
      if (noteA.size() == 0) check(1'b0, "unexpected stored result");
      else begin
        na = noteA.pop_front();
        check(cfgStored === na.cfg, "stored settings differ");
        check(illegalSetting === na.ill, "illegal flag differs");
      end
    end
    if (enD2) begin
      if (noteB.size() == 0) check(1'b0, "unexpected resolved result");
      else begin
        nb = noteB.pop_front();
        check(resolved.lowpassEffective === nb.res.lowpassEffective, "lowpass differs");
        check(resolved.cutoffMhz === nb.res.cutoffMhz, "cutoff differs");
        check(resolved.rateCsps === nb.res.rateCsps, "rate differs");
        check(resolved.modFreqHz === nb.res.modFreqHz, "modulation differs");
        check(driveOutPosOeN === nb.oeN && driveOutNegOeN === nb.oeN, "enable differs");
      end
    end
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    n_errors++;
    $display("Error at %0t: run did not finish", $time);
    stop_test();
  end

  initial begin
    cfgWrEn = 1'b0;
    cfgWrData = '0;
    illegalClr = 1'b0;
    srst = 1'b1;
    rng = 32'h0000001D;
    expIll = 1'b0;
    n_errors = 0;
    n_checks = 0;
    expCfg = '{BZR_FM_32768, 1'b0, 2'h1, 4'h8, 3'h0};
    repeat (20) @(posedge core_clk);
    #1 srst = 1'b0;
    repeat (2) @(posedge core_clk);
    #2;
    check(cfgStored === expCfg, "reset settings differ");
    check(resolved === res_exp(expCfg), "reset results differ");
    check(driveOutPosOeN === 1'b1 && driveOutNegOeN === 1'b1, "drive not floating");
    // every clock x rate x lowpass and every clock x modulation, magnitudes random
    for (int i = 0; i < 128; i++) begin
      rng = xorshift(rng);
      d = '{bzr_fmstr_t'(i[1:0]), i[2], i[4:3], i[6:3], rng[2:0]};
      step(1'b1, d, rng[3] & rng[4]);
      if (rng[5]) step(1'b0, d, rng[6]);
    end
    d = '{BZR_FM_32768, 1'b0, 2'h1, 4'h6, 3'h3};
    step(1'b1, d, 1'b1);
    step(1'b0, d, 1'b1);
    d.modulationFreqSelect = 4'h0;
    d.driveCurrentMagnitude = 3'h1;
    step(1'b1, d, 1'b0);
    step(1'b0, d, 1'b0);
    repeat (4) @(posedge core_clk);
    toggles = 0;
    badCnt = 0;
    prevPos = driveOutPos;
    // 200 us at 131072 Hz gives about 52 toggles; startup phase is not exact
    repeat (40000) begin
      @(posedge core_clk);
      #2;
      if (driveOutPos !== prevPos) toggles++;
      prevPos = driveOutPos;
      if (toggles > 0 && driveOutNeg !== ~driveOutPos) badCnt++;
    end
    check(toggles >= 50 && toggles <= 54, "drive frequency off");
    check(badCnt == 0, "drive phases not opposite");
    d.driveCurrentMagnitude = 3'h0;
    step(1'b1, d, 1'b0);
    step(1'b0, d, 1'b0);
    repeat (4) @(posedge core_clk);
    badCnt = 0;
    repeat (200) begin
      @(posedge core_clk);
      #2;
      if (driveOutPos !== 1'b0 || driveOutNeg !== 1'b0) badCnt++;
    end
    check(badCnt == 0, "drive active while off");
    check(noteA.size() == 0 && noteB.size() == 0, "results missing");
    stop_test();
  end

endmodule : testbench

`default_nettype wire
